// [port_ctrl_regs.vh]
// constants for the root hub downstream port status and control logic
`ifndef PORT_CTRL_REGS_VH
`define PORT_CTRL_REGS_VH
`define PORT1_STATUS_ADDR   4'h0
`define PORT2_STATUS_ADDR   4'h4
`define HUB_CTRL_ADDR       4'h8
`define BIT_CONNECT         0
`define BIT_ENABLE          1
`define BIT_SUSPEND         2
`define BIT_OVERCURRENT     3
`define BIT_RESET           4
`define BIT_POWER           8
`define BIT_LOW_SPEED       9
`define BIT_CONNECT_CHG     16
`define BIT_ENABLE_CHG      17
`define BIT_SUSPEND_CHG     18
`define BIT_OVERCURRENT_CHG 19
`define BIT_RESET_CHG       20
`define BIT_HUB_RESET       0
`define BIT_FIXED_DEV1      1
`define BIT_FIXED_DEV2      2
`define CLK_MHZ             250
`define RESET_SIG_US        10
`define RESUME_SIG_US       20
`define EOP_US              2
`define SYNC_DELAY_US       3000
`define RESET_SIG_CYC       (`RESET_SIG_US * `CLK_MHZ)
`define RESUME_SIG_CYC      (`RESUME_SIG_US * `CLK_MHZ)
`define EOP_CYC             (`EOP_US * `CLK_MHZ)
`define SYNC_DELAY_CYC      (`SYNC_DELAY_US * `CLK_MHZ)
`endif

// [port_engine.v]
// one downstream port: status flags, change flags and signalling timers
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module port_engine #(
  parameter RESET_CYC  = `RESET_SIG_CYC,
  parameter RESUME_CYC = `RESUME_SIG_CYC,
  parameter EOP_CYC    = `EOP_CYC,
  parameter SYNC_CYC   = `SYNC_DELAY_CYC
) (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        attached_i,
  input  wire        low_speed_i,
  input  wire        fixed_dev_i,
  input  wire        hub_reset_i,
  input  wire        wr_i,
  input  wire [31:0] wdata_i,
  output wire [31:0] status_o,
  output reg         reset_drive_o,
  output reg         resume_drive_o,
  output reg         suspend_o
);
  localparam ST_IDLE   = 3'd0;
  localparam ST_RESET  = 3'd1;
  localparam ST_RESUME = 3'd2;
  localparam ST_EOP    = 3'd3;
  localparam ST_SYNC   = 3'd4;
  reg  [2:0]  state_r;
  reg  [31:0] cnt_r;
  reg         connect_r;
  reg         attached_d_r;
  reg         enabled_r;
  reg         suspended_r;
  reg         reset_active_r;
  reg         power_r;
  reg         low_speed_r;
  reg         connect_change_r;
  reg         enable_change_r;
  reg         suspend_change_r;
  reg         reset_change_r;
  reg         en_nxt;
  reg         rst_nxt;
  wire        w_clr_en   = wr_i & wdata_i[`BIT_CONNECT];
  wire        w_set_en   = wr_i & wdata_i[`BIT_ENABLE];
  wire        w_set_susp = wr_i & wdata_i[`BIT_SUSPEND];
  wire        w_clr_susp = wr_i & wdata_i[`BIT_OVERCURRENT];
  wire        w_set_rst  = wr_i & wdata_i[`BIT_RESET];
  wire        w_set_pwr  = wr_i & wdata_i[`BIT_POWER];
  wire        w_clr_pwr  = wr_i & wdata_i[`BIT_LOW_SPEED];
  wire        cnt_done = (cnt_r == 32'h00000000);
  // an attached device or a fixed device pins connect high
  wire        conn_now = fixed_dev_i | attached_i;
  wire        conn_evt = ~fixed_dev_i & (attached_i != attached_d_r);
  wire        reset_end  = (state_r == ST_RESET) & cnt_done;
  wire        resume_end = (state_r == ST_SYNC) & cnt_done;
  // disconnected set-enable, set-suspend and set-reset commands bump connect change
  wire        bad_cmd = ~connect_r & (w_set_rst | w_set_en | w_set_susp);
  always @* begin
    en_nxt = enabled_r;
    if (w_clr_en) begin
      en_nxt = 1'b0;
    end
    if (w_set_en & connect_r) begin
      en_nxt = 1'b1;
    end
    if (reset_end | resume_end) begin
      en_nxt = 1'b1;
    end
    if (~connect_r) begin
      en_nxt = 1'b0;
    end
    rst_nxt = reset_active_r;
    // only an idle port starts a reset, so the flag never sticks without a timer
    if (w_set_rst & connect_r & (state_r == ST_IDLE)) begin
      rst_nxt = 1'b1;
    end
    if (reset_end) begin
      rst_nxt = 1'b0;
    end
    // a pulled plug aborts the reset and still counts as a change
    if (~conn_now) begin
      rst_nxt = 1'b0;
    end
  end
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r          <= ST_IDLE;
      cnt_r            <= 32'h00000000;
      connect_r        <= 1'b0;
      attached_d_r     <= 1'b0;
      enabled_r        <= 1'b0;
      suspended_r      <= 1'b0;
      reset_active_r   <= 1'b0;
      power_r          <= 1'b0;
      low_speed_r      <= 1'b0;
      connect_change_r <= 1'b0;
      enable_change_r  <= 1'b0;
      suspend_change_r <= 1'b0;
      reset_change_r   <= 1'b0;
      reset_drive_o    <= 1'b0;
      resume_drive_o   <= 1'b0;
      suspend_o        <= 1'b0;
    end else begin
      attached_d_r   <= attached_i;
      connect_r      <= conn_now;
      low_speed_r    <= low_speed_i;
      enabled_r      <= en_nxt;
      reset_active_r <= rst_nxt;
      if (w_set_pwr) begin
        power_r <= 1'b1;
      end else if (w_clr_pwr) begin
        power_r <= 1'b0;
      end
      // set wins over the write-one clear on every change flag
      if (conn_evt | bad_cmd | (hub_reset_i & fixed_dev_i)) begin
        connect_change_r <= 1'b1;
      end else if (wr_i & wdata_i[`BIT_CONNECT_CHG]) begin
        connect_change_r <= 1'b0;
      end
      if (en_nxt != enabled_r) begin
        enable_change_r <= 1'b1;
      end else if (wr_i & wdata_i[`BIT_ENABLE_CHG]) begin
        enable_change_r <= 1'b0;
      end
      if (resume_end) begin
        suspend_change_r <= 1'b1;
      end else if (wr_i & wdata_i[`BIT_SUSPEND_CHG]) begin
        suspend_change_r <= 1'b0;
      end
      if (rst_nxt != reset_active_r) begin
        reset_change_r <= 1'b1;
      end else if (wr_i & wdata_i[`BIT_RESET_CHG]) begin
        reset_change_r <= 1'b0;
      end
      if (cnt_r != 32'h00000000) begin
        cnt_r <= cnt_r - 32'h00000001;
      end
      case (state_r)
        ST_IDLE: begin
          if (w_set_rst & connect_r) begin
            state_r       <= ST_RESET;
            cnt_r         <= RESET_CYC - 1;
            reset_drive_o <= 1'b1;
          end else if (w_clr_susp & suspended_r) begin
            state_r        <= ST_RESUME;
            cnt_r          <= RESUME_CYC - 1;
            resume_drive_o <= 1'b1;
          end else if (w_set_susp & connect_r) begin
            suspended_r <= 1'b1;
            suspend_o   <= 1'b1;
          end
        end
        ST_RESET: begin
          if (cnt_done) begin
            state_r       <= ST_IDLE;
            reset_drive_o <= 1'b0;
            suspended_r   <= 1'b0;
            suspend_o     <= 1'b0;
          end
        end
        ST_RESUME: begin
          if (cnt_done) begin
            state_r        <= ST_EOP;
            cnt_r          <= EOP_CYC - 1;
            resume_drive_o <= 1'b0;
          end
        end
        ST_EOP: begin
          if (cnt_done) begin
            state_r   <= ST_SYNC;
            cnt_r     <= SYNC_CYC - 1;
            suspend_o <= 1'b0;
          end
        end
        ST_SYNC: begin
          if (cnt_done) begin
            state_r     <= ST_IDLE;
            suspended_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      if (~conn_now) begin
        state_r        <= ST_IDLE;
        reset_drive_o  <= 1'b0;
        resume_drive_o <= 1'b0;
        suspend_o      <= 1'b0;
        suspended_r    <= 1'b0;
      end
    end
  end
  // overcurrent bits tied low, other gaps zero
  assign status_o = {11'h000, reset_change_r, 1'b0, suspend_change_r, enable_change_r,
                     connect_change_r, 6'h00, low_speed_r, power_r, 3'h0, reset_active_r,
                     1'b0, suspended_r, enabled_r, connect_r};
endmodule // port_engine

// [root_port_ctrl.v]
// root hub with two downstream port status and control registers
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module root_port_ctrl #(
  parameter SYNC_CYC = `SYNC_DELAY_CYC
) (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [1:0]  attached_i,
  input  wire [1:0]  low_speed_i,
  output reg  [1:0]  reset_drive_o,
  output reg  [1:0]  resume_drive_o,
  output reg  [1:0]  suspend_o
);
  reg  [2:0]  hub_ctrl_r;
  reg  [1:0]  hub_reset_r;
  wire [31:0] st1;
  wire [31:0] st2;
  wire [1:0]  rdrv;
  wire [1:0]  mdrv;
  wire [1:0]  sdrv;
  wire        wr_hub = wr_i & (addr_i == `HUB_CTRL_ADDR);
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hub_ctrl_r     <= 3'h0;
      hub_reset_r    <= 2'h0;
      rdata_o        <= 32'h00000000;
      reset_drive_o  <= 2'h0;
      resume_drive_o <= 2'h0;
      suspend_o      <= 2'h0;
    end else begin
      if (wr_hub) begin
        hub_ctrl_r <= {wdata_i[`BIT_FIXED_DEV2], wdata_i[`BIT_FIXED_DEV1], 1'b0};
      end
      hub_reset_r    <= {2{wr_hub & wdata_i[`BIT_HUB_RESET]}};
      reset_drive_o  <= rdrv;
      resume_drive_o <= mdrv;
      suspend_o      <= sdrv;
      rdata_o        <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `PORT1_STATUS_ADDR: rdata_o <= st1;
          `PORT2_STATUS_ADDR: rdata_o <= st2;
          `HUB_CTRL_ADDR:     rdata_o <= {29'h0, hub_ctrl_r};
          default:            rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
  port_engine #(.SYNC_CYC(SYNC_CYC)) u_port1 (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .attached_i     (attached_i[0]),
    .low_speed_i    (low_speed_i[0]),
    .fixed_dev_i    (hub_ctrl_r[`BIT_FIXED_DEV1]),
    .hub_reset_i    (hub_reset_r[0]),
    .wr_i           (wr_i & (addr_i == `PORT1_STATUS_ADDR)),
    .wdata_i        (wdata_i),
    .status_o       (st1),
    .reset_drive_o  (rdrv[0]),
    .resume_drive_o (mdrv[0]),
    .suspend_o      (sdrv[0])
  );
  port_engine #(.SYNC_CYC(SYNC_CYC)) u_port2 (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .attached_i     (attached_i[1]),
    .low_speed_i    (low_speed_i[1]),
    .fixed_dev_i    (hub_ctrl_r[`BIT_FIXED_DEV2]),
    .hub_reset_i    (hub_reset_r[1]),
    .wr_i           (wr_i & (addr_i == `PORT2_STATUS_ADDR)),
    .wdata_i        (wdata_i),
    .status_o       (st2),
    .reset_drive_o  (rdrv[1]),
    .resume_drive_o (mdrv[1]),
    .suspend_o      (sdrv[1])
  );
endmodule // root_port_ctrl

// [root_port_ctrl_asserts.sv]
// timing checker on the root hub port control block
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module root_port_ctrl_chk #(parameter SYNC_CYC = 20) (
  input wire        sys_clk_i,
  input wire        nrst_i,
  input wire [3:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire [1:0]  attached_i,
  input wire [1:0]  low_speed_i,
  input wire [1:0]  reset_drive_o,
  input wire [1:0]  resume_drive_o,
  input wire [1:0]  suspend_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  reg  [1:0] att_r;
  // connect bit lags attach, so only trust a settled attach
  wire       go2 = wr_i && addr_i == 4'h4 && att_r[1] && attached_i[1] && !suspend_o[1];
  always @(posedge sys_clk_i) att_r <= attached_i;
  // reset pulse is longer than a repetition can unroll, so count it
  reg  [11:0] rst_len_r;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_len_r <= 12'h000;
    end else if (reset_drive_o[1]) begin
      rst_len_r <= rst_len_r + 12'h001;
    end else begin
      rst_len_r <= 12'h000;
    end
  end
  ////////////////////////////////////////////////////////////////
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  spare_bits_a: assert property ($past(rd_i) |-> (rdata_o & 32'hFFE8_FCE8) == 32'h0)
    else $error("reserved or overcurrent bit set");
  reset_start_a: assert property (go2 && wdata_i[4] && !reset_drive_o[1]
    |-> ##[1:3] reset_drive_o[1]) else $error("reset not started");
  reset_len_a: assert property ($fell(reset_drive_o[1]) && attached_i[1] && att_r[1]
    |-> rst_len_r == `RESET_SIG_CYC) else $error("reset length wrong");
  port1_reset_a: assert property (wr_i && addr_i == 4'h0 && wdata_i[4] && att_r[0]
    && attached_i[0] && !suspend_o[0] && !reset_drive_o[0] |-> ##[1:3] reset_drive_o[0])
    else $error("first port reset not started");
  resume_cause_a: assert property ($rose(resume_drive_o[1]) |-> $past(suspend_o[1]))
    else $error("resume without suspend");
  resume_susp_a: assert property (resume_drive_o[1] |-> suspend_o[1])
    else $error("suspend low during resume");
  suspend_start_a: assert property (go2 && wdata_i[2] && !wdata_i[4]
    && !reset_drive_o[1] |-> ##[1:3] suspend_o[1]) else $error("suspend not entered");
  cover property ($fell(reset_drive_o[1]));
  cover property ($fell(suspend_o[1]));
  cover property ($rose(reset_drive_o[0]));
endmodule // root_port_ctrl_chk
bind root_port_ctrl root_port_ctrl_chk #(.SYNC_CYC(SYNC_CYC)) chk (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .attached_i(attached_i), .low_speed_i(low_speed_i),
  .reset_drive_o(reset_drive_o), .resume_drive_o(resume_drive_o), .suspend_o(suspend_o));

// [root_port_ctrl_test.sv]
// self-checking bench for the root hub port control block
`timescale 1ns/10ps
module root_port_ctrl_test;
  localparam [3:0] P2 = 4'h4;
  reg         sys_clk_i, nrst_i, wr_i, rd_i;
  reg  [3:0]  addr_i;
  reg  [31:0] wdata_i;
  reg  [1:0]  plug, slow;
  wire [31:0] rdata_o;
  wire [1:0]  att, lsp, rst_drv, res_drv, susp;
  int         error_cnt, n_compared;
  root_port_ctrl #(.SYNC_CYC(20)) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .attached_i(att), .low_speed_i(lsp), .reset_drive_o(rst_drv),
    .resume_drive_o(res_drv), .suspend_o(susp));
  usb_dev_model dev0 (.plug_i(plug[0]), .slow_i(slow[0]), .attached_o(att[0]),
    .low_speed_o(lsp[0]));
  usb_dev_model dev1 (.plug_i(plug[1]), .slow_i(slow[1]), .attached_o(att[1]),
    .low_speed_o(lsp[1]));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input [1:0] got, input [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic rd_chk(input [3:0] a, input [31:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_idle;
    rd_chk(P2, 32'h0);
    rd_chk(4'hC, 32'h0);
  endtask
  task t_no_device;
    bit [31:0] cmd[4] = '{32'h2, 32'h4, 32'h10, 32'h8};
    bit [31:0] exp[4] = '{32'h1_0000, 32'h1_0000, 32'h1_0000, 32'h0};
    foreach (cmd[i]) begin
      wr(P2, cmd[i]);
      rd_chk(P2, exp[i]);
      wr(P2, 32'h0001_0000);
    end
    rd_chk(P2, 32'h0);
  endtask
  task t_power;
    wr(P2, 32'h100);
    wr(P2, 32'hFFE0_FCE0);
    rd_chk(P2, 32'h100);
    wr(P2, 32'h200);
    rd_chk(P2, 32'h0);
  endtask
  task t_attach_enable;
    @(posedge sys_clk_i);
    plug[1] <= 1'b1;
    slow[1] <= 1'b1;
    wait_cyc(4);
    rd_chk(P2, 32'h0001_0201);
    wr(P2, 32'h0001_0000);
    wr(P2, 32'h2);
    rd_chk(P2, 32'h0002_0203);
    wr(P2, 32'h1);
    rd_chk(P2, 32'h0002_0201);
    wr(P2, 32'h0002_0000);
  endtask
  task t_port_reset;
    wr(P2, 32'h10);
    rd_chk(P2, 32'h0010_0211);
    chk_pin(rst_drv, 2'b10);
    wait_cyc(2600);
    rd_chk(P2, 32'h0012_0203);
    chk_pin(rst_drv, 2'b00);
    wr(P2, 32'h0012_0000);
  endtask
  task t_suspend_resume;
    wr(P2, 32'h4);
    rd_chk(P2, 32'h207);
    chk_pin(susp, 2'b10);
    wr(P2, 32'h1);
    wr(P2, 32'h0002_0000);
    wr(P2, 32'h8);
    rd_chk(P2, 32'h205);
    chk_pin(res_drv, 2'b10);
    wait_cyc(5600);
    rd_chk(P2, 32'h0006_0203);
    chk_pin(susp, 2'b00);
    chk_pin(res_drv, 2'b00);
    wr(P2, 32'h0006_0000);
  endtask
  task t_first_port;
    @(posedge sys_clk_i);
    plug[0] <= 1'b1;
    wait_cyc(4);
    wr(4'h0, 32'h10);
    rd_chk(4'h0, 32'h0011_0011);
    chk_pin(rst_drv, 2'b01);
  endtask
  task t_fixed_dev;
    wr(P2, 32'h0003_0000);
    wr(4'h8, 32'h0000_0005);
    rd_chk(P2, 32'h0001_0001);
    rd_chk(4'h8, 32'h0000_0004);
  endtask
  task t_detach;
    @(posedge sys_clk_i);
    plug[1] <= 1'b0;
    slow[1] <= 1'b0;
    wait_cyc(4);
    rd_chk(P2, 32'h0003_0000);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    wait_cyc(40000);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    {nrst_i, wr_i, rd_i, addr_i, wdata_i, plug, slow} = '0;
    error_cnt  = 0;
    n_compared = 0;
    wait_cyc(4);
    nrst_i <= 1'b1;
    t_idle;
    t_no_device;
    t_power;
    t_attach_enable;
    t_port_reset;
    t_suspend_resume;
    t_first_port;
    t_detach;
    t_fixed_dev;
    tally_and_finish;
  end
endmodule // root_port_ctrl_test

// [usb_dev_model.sv]
// attached usb device: plug state and speed seen on the port lines
`timescale 1ns/10ps
module usb_dev_model (
  input  wire plug_i,
  input  wire slow_i,
  output wire attached_o,
  output wire low_speed_o
);
  assign attached_o  = plug_i;
  // unplugged lines fall to the pull-down level, never the old speed
  assign low_speed_o = plug_i & slow_i;
endmodule // usb_dev_model
